/* File: src/rpd_pkg.sv */
// Purpose: Constants for the cyclic receive image decoder
// Assumes: APB register access, 32-bit data, one clock
// Notes: Object numbers run 0..7 for receive objects 1..8
package rpd_pkg;
   // Receive objects and image size
   localparam int NUM_OBJ = 8;
   localparam int IMG_WORDS = 8;
   localparam int IMG_BITS = 256;
   localparam logic [2:0] OBJ_ENCODER_COMPACT = 3'h0;
   localparam logic [2:0] OBJ_ENCODER_FULL = 3'h1;
   localparam logic [2:0] OBJ_STEPPER_CTRL = 3'h2;
   localparam logic [2:0] OBJ_STEPPER_POS = 3'h3;
   localparam logic [2:0] OBJ_STEPPER_VEL = 3'h4;
   localparam logic [2:0] OBJ_POS_COMPACT = 3'h5;
   localparam logic [2:0] OBJ_POS_FULL = 3'h6;
   localparam logic [2:0] OBJ_POS_SECOND = 3'h7;

   // Bit length of each receive object, padding included
   localparam logic [7:0] OBJ_BITS [NUM_OBJ] = '{8'h20, 8'h30, 8'h10, 8'h20,
                                                 8'h10, 8'h30, 8'h70, 8'h70};

   // Parameter object: highest subindex and exclusion strings (octet 0 lowest)
   localparam logic [7:0] MAX_SUBIDX = 8'h06;
   localparam logic [7:0] MAP_INDEX_HI = 8'h16;
   localparam logic [47:0] EXCL_STR [NUM_OBJ] = '{
      48'h0000_0000_1601, 48'h0000_0000_1600, 48'h0000_0000_0000,
      48'h1606_1605_1604, 48'h1606_1605_1603, 48'h1606_1604_1603,
      48'h1605_1604_1603, 48'h1605_1604_1603};

   // Encoder control layout
   localparam int ENCODER_REF_POS = 0;
   localparam int ENCODER_RISE_POS = 1;
   localparam int ENCODER_LOAD_POS = 2;
   localparam int ENCODER_FALL_POS = 3;
   localparam int ENCODER_PAD_POS = 4;
   localparam int ENCODER_PAD_LEN = 12;
   localparam int ENCODER_PRESET_POS = ENCODER_PAD_POS + ENCODER_PAD_LEN;
   localparam int ENCODER_PRESET_SHORT = 16;

   // Stepper control layout
   localparam int STEPPER_ENABLE_POS = 0;
   localparam int STEPPER_FAULT_POS = 1;
   localparam int STEPPER_TORQUE_POS = 2;
   localparam int STEPPER_PAD1_POS = 3;
   localparam int STEPPER_PAD1_LEN = 8;
   localparam int STEPPER_DOUT_POS = STEPPER_PAD1_POS + STEPPER_PAD1_LEN;
   localparam int STEPPER_PAD2_LEN = 4;

   // Register offsets
   localparam logic [11:0] ADDR_ASSIGN = 12'h000;
   localparam logic [11:0] ADDR_CTRL = 12'h004;
   localparam logic [11:0] ADDR_STATUS = 12'h008;
   localparam logic [11:0] ADDR_PARAM_SEL = 12'h00C;
   localparam logic [11:0] ADDR_PARAM_INFO = 12'h010;
   localparam logic [11:0] ADDR_EXCL_LO = 12'h014;
   localparam logic [11:0] ADDR_EXCL_HI = 12'h018;
   localparam logic [11:0] ADDR_IMG_BASE = 12'h020;
   localparam logic [11:0] ADDR_IMG_LAST = 12'h03C;

   // Register fields and reset values
   localparam int CTRL_COMMIT_BIT = 0;
   localparam int STATUS_CONFLICT_BIT = 0;
   localparam int STATUS_REJECT_BIT = 1;
   localparam int STATUS_COUNT_POS = 8;
   localparam logic [7:0] ASSIGN_RESET = 8'h00;
   localparam logic [2:0] PARAM_SEL_RESET = 3'h0;
endpackage

/* File: src/rpd_rx_decoder.sv */
// Purpose: Decodes the cyclic receive image into encoder and stepper fields
// Assumes: APB master, zero-wait slave answering one cycle after setup
// Notes: Image words and object assignment are written over APB; a commit
//        write stands for the arrival of one cyclic frame.
//
// The APB interface to the registers and the register offsets were left to the implementer.
module rpd_rx_decoder (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Encoder channel controls
   output logic encoder_latch_ref,
   output logic encoder_latch_rise,
   output logic encoder_counter_load,
   output logic encoder_latch_fall,
   output logic [31:0] encoder_preset,
   // Stepper channel controls
   output logic stepper_enable,
   output logic stepper_fault_reset,
   output logic stepper_reduce_torque,
   output logic stepper_dout,
   output logic [31:0] stepper_target_pos,
   output logic [15:0] stepper_velocity,
   // Frame events
   output logic frame_accepted,
   output logic frame_rejected
);

   logic [7:0] assign_reg;
   logic [2:0] param_sel_reg;
   logic reject_reg;
   logic [7:0] count_reg;
   logic [31:0] img_reg [rpd_pkg::IMG_WORDS];
   logic [rpd_pkg::IMG_BITS-1:0] img_flat;
   logic [7:0] excl_mask [rpd_pkg::NUM_OBJ];
   logic conflict;
   logic setup_ph;
   logic write_ph;
   logic commit;
   logic addr_ok;
   logic [31:0] rdata_next;

   // Turn an exclusion string into a mask of forbidden objects
   function automatic logic [7:0] excl_to_mask(input logic [47:0] str);
      logic [7:0] m;
      m = 8'h00;
      for (int i = 0; i < 3; i++) begin
         if (str[16*i+8 +: 8] == rpd_pkg::MAP_INDEX_HI) begin
            m[str[16*i +: 3]] = 1'b1;
         end
      end
      return m;
   endfunction

   // Bit offset of an object: sum of the assigned objects mapped before it
   function automatic logic [7:0] obj_offset(input logic [7:0] asg, input logic [2:0] k);
      logic [7:0] off;
      off = 8'h00;
      for (int i = 0; i < rpd_pkg::NUM_OBJ; i++) begin
         if (i < int'(k) && asg[i]) begin
            off = off + rpd_pkg::OBJ_BITS[i];
         end
      end
      return off;
   endfunction

   // Image word at a bit offset, LSB first
   function automatic logic [31:0] fetch(input logic [rpd_pkg::IMG_BITS-1:0] img,
                                         input logic [7:0] off);
      logic [rpd_pkg::IMG_BITS-1:0] sh;
      sh = img >> off;
      return sh[31:0];
   endfunction

   // Flatten the image words, word 0 lowest
   generate
      for (genvar w = 0; w < rpd_pkg::IMG_WORDS; w++) begin : g_flat
         assign img_flat[32*w +: 32] = img_reg[w];
      end
   endgenerate

   generate
      for (genvar o = 0; o < rpd_pkg::NUM_OBJ; o++) begin : g_excl
         assign excl_mask[o] = excl_to_mask(rpd_pkg::EXCL_STR[o]);
      end
   endgenerate

   // conflict when an assigned object meets a forbidden one
   always_comb begin
      conflict = 1'b0;
      for (int o = 0; o < rpd_pkg::NUM_OBJ; o++) begin
         if (assign_reg[o] && (excl_mask[o] & assign_reg) != 8'h00) begin
            conflict = 1'b1;
         end
      end
   end

   // Bus phase decode; writes land only at the access edge with pready high
   assign setup_ph = psel && !penable;
   assign write_ph = psel && penable && pready && pwrite;
   assign commit = write_ph && paddr == rpd_pkg::ADDR_CTRL && pwdata[rpd_pkg::CTRL_COMMIT_BIT];
   assign addr_ok = paddr == rpd_pkg::ADDR_ASSIGN || paddr == rpd_pkg::ADDR_CTRL ||
                    paddr == rpd_pkg::ADDR_STATUS || paddr == rpd_pkg::ADDR_PARAM_SEL ||
                    paddr == rpd_pkg::ADDR_PARAM_INFO || paddr == rpd_pkg::ADDR_EXCL_LO ||
                    paddr == rpd_pkg::ADDR_EXCL_HI ||
                    (paddr >= rpd_pkg::ADDR_IMG_BASE && paddr <= rpd_pkg::ADDR_IMG_LAST &&
                     paddr[1:0] == 2'b00);

   // Read mux
   always_comb begin
      rdata_next = 32'h0000_0000;
      case (paddr)
         rpd_pkg::ADDR_ASSIGN: begin
            rdata_next[7:0] = assign_reg;
         end
         // Commit strobe is write-only; keeps image word 1 off this address
         rpd_pkg::ADDR_CTRL: begin
            rdata_next = 32'h0000_0000;
         end
         rpd_pkg::ADDR_STATUS: begin
            rdata_next[rpd_pkg::STATUS_CONFLICT_BIT] = conflict;
            rdata_next[rpd_pkg::STATUS_REJECT_BIT] = reject_reg;
            rdata_next[rpd_pkg::STATUS_COUNT_POS +: 8] = count_reg;
         end
         rpd_pkg::ADDR_PARAM_SEL: begin
            rdata_next[2:0] = param_sel_reg;
         end
         rpd_pkg::ADDR_PARAM_INFO: begin
            rdata_next[7:0] = rpd_pkg::MAX_SUBIDX;
         end
         rpd_pkg::ADDR_EXCL_LO: begin
            rdata_next = rpd_pkg::EXCL_STR[param_sel_reg][31:0];
         end
         rpd_pkg::ADDR_EXCL_HI: begin
            rdata_next[15:0] = rpd_pkg::EXCL_STR[param_sel_reg][47:32];
         end
         default: begin
            if (addr_ok) begin
               rdata_next = img_reg[paddr[4:2]];
            end
         end
      endcase
   end

   // APB answer: one-cycle pready after each setup, data latched then
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         pready <= 1'b0;
         prdata <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else begin
         pready <= setup_ph;
         prdata <= (setup_ph && !pwrite && addr_ok) ? rdata_next : 32'h0000_0000;
         pslverr <= setup_ph && !addr_ok;
      end
   end

   // Assignment and parameter select registers
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         assign_reg <= rpd_pkg::ASSIGN_RESET;
         param_sel_reg <= rpd_pkg::PARAM_SEL_RESET;
      end else if (write_ph) begin
         if (paddr == rpd_pkg::ADDR_ASSIGN) begin
            assign_reg <= pwdata[7:0];
         end
         if (paddr == rpd_pkg::ADDR_PARAM_SEL) begin
            param_sel_reg <= pwdata[2:0];
         end
      end
   end

   // Image words; no reset needed for data, but cleared for determinism
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         for (int w = 0; w < rpd_pkg::IMG_WORDS; w++) begin
            img_reg[w] <= 32'h0000_0000;
         end
      end else if (write_ph && paddr >= rpd_pkg::ADDR_IMG_BASE &&
                   paddr <= rpd_pkg::ADDR_IMG_LAST && paddr[1:0] == 2'b00) begin
         img_reg[paddr[4:2]] <= pwdata;
      end
   end

   // Reject flag: write one to clear, a new reject wins over the clear
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         reject_reg <= 1'b0;
      end else if (commit && conflict) begin
         reject_reg <= 1'b1;
      end else if (write_ph && paddr == rpd_pkg::ADDR_STATUS &&
                   pwdata[rpd_pkg::STATUS_REJECT_BIT]) begin
         reject_reg <= 1'b0;
      end
   end

   // Frame events and accepted-frame counter
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         frame_accepted <= 1'b0;
         frame_rejected <= 1'b0;
         count_reg <= 8'h00;
      end else begin
         frame_accepted <= commit && !conflict;
         frame_rejected <= commit && conflict;
         if (commit && !conflict) begin
            count_reg <= count_reg + 8'h01;
         end
      end
   end

   // fields hold until a valid frame that carries their object
   // Encoder controls from whichever encoder object is assigned
   always_ff @(posedge clk) begin : p_encoder
      logic [31:0] wd;
      logic [7:0] off;
      if (!rst_b) begin
         encoder_latch_ref <= 1'b0;
         encoder_latch_rise <= 1'b0;
         encoder_counter_load <= 1'b0;
         encoder_latch_fall <= 1'b0;
         encoder_preset <= 32'h0000_0000;
      end else if (commit && !conflict &&
                   (assign_reg[rpd_pkg::OBJ_ENCODER_COMPACT] ||
                    assign_reg[rpd_pkg::OBJ_ENCODER_FULL])) begin
         off = assign_reg[rpd_pkg::OBJ_ENCODER_COMPACT] ?
               obj_offset(assign_reg, rpd_pkg::OBJ_ENCODER_COMPACT) :
               obj_offset(assign_reg, rpd_pkg::OBJ_ENCODER_FULL);
         wd = fetch(img_flat, off + 8'(rpd_pkg::ENCODER_PRESET_POS));
         encoder_latch_ref <= img_flat[off + 8'(rpd_pkg::ENCODER_REF_POS)];
         encoder_latch_rise <= img_flat[off + 8'(rpd_pkg::ENCODER_RISE_POS)];
         encoder_counter_load <= img_flat[off + 8'(rpd_pkg::ENCODER_LOAD_POS)];
         encoder_latch_fall <= img_flat[off + 8'(rpd_pkg::ENCODER_FALL_POS)];
         if (assign_reg[rpd_pkg::OBJ_ENCODER_COMPACT]) begin
            encoder_preset <= {16'h0000, wd[rpd_pkg::ENCODER_PRESET_SHORT-1:0]};
         end else begin
            encoder_preset <= wd;
         end
      end
   end

   // Stepper control object
   always_ff @(posedge clk) begin : p_stepper_ctrl
      logic [7:0] off;
      if (!rst_b) begin
         stepper_enable <= 1'b0;
         stepper_fault_reset <= 1'b0;
         stepper_reduce_torque <= 1'b0;
         stepper_dout <= 1'b0;
      end else if (commit && !conflict && assign_reg[rpd_pkg::OBJ_STEPPER_CTRL]) begin
         off = obj_offset(assign_reg, rpd_pkg::OBJ_STEPPER_CTRL);
         stepper_enable <= img_flat[off + 8'(rpd_pkg::STEPPER_ENABLE_POS)];
         stepper_fault_reset <= img_flat[off + 8'(rpd_pkg::STEPPER_FAULT_POS)];
         stepper_reduce_torque <= img_flat[off + 8'(rpd_pkg::STEPPER_TORQUE_POS)];
         stepper_dout <= img_flat[off + 8'(rpd_pkg::STEPPER_DOUT_POS)];
      end
   end

   // Stepper target position
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         stepper_target_pos <= 32'h0000_0000;
      end else if (commit && !conflict && assign_reg[rpd_pkg::OBJ_STEPPER_POS]) begin
         stepper_target_pos <= fetch(img_flat, obj_offset(assign_reg, rpd_pkg::OBJ_STEPPER_POS));
      end
   end

   // Stepper velocity setpoint
   always_ff @(posedge clk) begin : p_stepper_vel
      logic [31:0] wd;
      if (!rst_b) begin
         stepper_velocity <= 16'h0000;
      end else if (commit && !conflict && assign_reg[rpd_pkg::OBJ_STEPPER_VEL]) begin
         wd = fetch(img_flat, obj_offset(assign_reg, rpd_pkg::OBJ_STEPPER_VEL));
         stepper_velocity <= wd[15:0];
      end
   end

endmodule

/* File: verif/rpd_rx_decoder_properties.sv */
// Purpose: Port-level properties of the receive image decoder
// Assumes: One clock, synchronous active-low reset
// Notes: Watches APB inputs and design outputs; bound after the module
module rpd_rx_decoder_chk (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // APB
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // Decoded fields and events
   input wire logic [31:0] encoder_preset,
   input wire logic encoder_latch_ref,
   input wire logic [31:0] stepper_target_pos,
   input wire logic [15:0] stepper_velocity,
   input wire logic stepper_enable,
   input wire logic frame_accepted,
   input wire logic frame_rejected
);
   default clocking dc @(posedge clk);
   endclocking
   default disable iff (!rst_b);
   // Commit write landing at this edge
   logic commit;
   assign commit = psel && penable && pwrite && pready && paddr == rpd_pkg::ADDR_CTRL && pwdata[0];

   property p_ready_after_setup;
      psel && !penable |=> pready;
   endproperty
   a_ready_after_setup: assert property (p_ready_after_setup) else $error("late pready");
   property p_ready_single;
      pready |=> !pready;
   endproperty
   a_ready_single: assert property (p_ready_single) else $error("pready too long");
   property p_err_with_ready;
      pslverr |-> pready;
   endproperty
   a_err_with_ready: assert property (p_err_with_ready) else $error("stray pslverr");
   property p_rdata_idle;
      !pready |-> prdata == 32'h0000_0000;
   endproperty
   a_rdata_idle: assert property (p_rdata_idle) else $error("prdata not idle");
   property p_commit_answer;
      commit |=> frame_accepted != frame_rejected;
   endproperty
   a_commit_answer: assert property (p_commit_answer) else $error("no frame verdict");
   property p_event_cause;
      frame_accepted || frame_rejected |-> $past(commit);
   endproperty
   a_event_cause: assert property (p_event_cause) else $error("verdict without commit");
   property p_hold_stepper;
      !frame_accepted |-> $stable({stepper_target_pos, stepper_velocity, stepper_enable});
   endproperty
   a_hold_stepper: assert property (p_hold_stepper) else $error("stepper field moved");
   property p_hold_encoder;
      !frame_accepted |-> $stable({encoder_preset, encoder_latch_ref});
   endproperty
   a_hold_encoder: assert property (p_hold_encoder) else $error("encoder field moved");
   c_accept: cover property (frame_accepted);
   c_reject: cover property (frame_rejected);
   c_slverr: cover property (pslverr);
endmodule

bind rpd_rx_decoder rpd_rx_decoder_chk u_chk (
   .clk, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
   .encoder_preset, .encoder_latch_ref, .stepper_target_pos, .stepper_velocity,
   .stepper_enable, .frame_accepted, .frame_rejected
);

/* File: verif/rpd_apb_master.sv */
// Purpose: APB master standing in for the cyclic image source
// Assumes: Slave answers by raising pready
// Notes: Signals move only right after a rising edge
module rpd_apb_master (
   // Clock
   input wire logic clk,
   // APB
   output logic psel,
   output logic penable,
   output logic pwrite,
   output logic [11:0] paddr,
   output logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr
);
   timeunit 1ns;
   timeprecision 1ps;
   // Idle bus at time zero
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0000_0000;
   end
   // One transfer, held until pready; released data shows its inverse
   task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e, output logic to);
      int n;
      n = 0;
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      to = (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      pwdata <= ~d;
   endtask
endmodule

/* File: verif/rx_process_image_decoder_tb.sv */
// Purpose: Self-checking bench for the receive image decoder
// Assumes: APB master model drives the bus
// Notes: Frame results are queued by the driver, checked by a monitor
module rx_process_image_decoder_tb;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct packed {
      logic acc;
      logic [3:0] encoder_channel;
      logic [31:0] pre;
      logic [3:0] stp;
      logic [31:0] pos;
      logic [15:0] vel;
   } rpd_exp_t;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic psel, penable, pwrite, pready, pslverr, fa, fr, er;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, preset, pos, rd;
   logic [31:0] seed = 32'h0000_0038;
   logic [15:0] vel;
   logic [3:0] encoder_channel, stp;
   logic [255:0] img;
   logic [7:0] bad [7] = '{8'h18, 8'h30, 8'h28, 8'h48, 8'h88, 8'h03, 8'h60};
   logic [47:0] excl [8] = '{48'h1601, 48'h1600, 48'h0, 48'h1606_1605_1604,
      48'h1606_1605_1603, 48'h1606_1604_1603, 48'h1605_1604_1603, 48'h1605_1604_1603};
   int num_errors = 0;
   int comparisons = 0;
   rpd_exp_t expq[$];
   rpd_exp_t st, mon;

   always #20 clk = ~clk;
   rpd_apb_master bfm (.clk, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
      .pslverr);
   rpd_rx_decoder dut (.clk, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .encoder_latch_ref(encoder_channel[0]), .encoder_latch_rise(encoder_channel[1]),
      .encoder_counter_load(encoder_channel[2]), .encoder_latch_fall(encoder_channel[3]), .encoder_preset(preset),
      .stepper_enable(stp[0]), .stepper_fault_reset(stp[1]), .stepper_reduce_torque(stp[2]),
      .stepper_dout(stp[3]), .stepper_target_pos(pos), .stepper_velocity(vel),
      .frame_accepted(fa), .frame_rejected(fr));

   task automatic check(input string what, input logic [47:0] seen, input logic [47:0] exp);
      comparisons++;
      if (seen !== exp) begin
         num_errors++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic report_and_stop();
      $display("errors %0d comparisons %0d", num_errors, comparisons);
      if (num_errors == 0 && comparisons > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
      logic to;
      bfm.xfer(w, a, d, rd, er, to);
      if (to) begin
         num_errors++;
         report_and_stop();
      end
   endtask
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   // Random image, padding included, so skipped gaps carry noise
   task automatic fill();
      for (int i = 0; i < 8; i++) begin
         img[32 * i +: 32] = rnd();
      end
   endtask
   // Load assignment and image, note the verdict, then commit
   task automatic frame(input logic [7:0] asg, input logic acc);
      rpd_exp_t e;
      e = st;
      e.acc = acc;
      bus(1'b1, rpd_pkg::ADDR_ASSIGN, {24'h0, asg});
      for (int i = 0; i < 8; i++) begin
         bus(1'b1, rpd_pkg::ADDR_IMG_BASE + 12'(4 * i), img[32 * i +: 32]);
      end
      expq.push_back(e);
      bus(1'b1, rpd_pkg::ADDR_CTRL, 32'h0000_0001);
   endtask

   // Monitor: each verdict pulse takes the oldest note
   always @(posedge clk) begin
      if (fa === 1'b1 || fr === 1'b1) begin
         mon = expq.pop_front();
         check("verdict", {fa, fr}, {mon.acc, ~mon.acc});
         check("encoder", {encoder_channel, preset}, {mon.encoder_channel, mon.pre});
         check("stp_ctrl", stp, mon.stp);
         check("stp_pos", pos, mon.pos);
         check("stp_vel", vel, mon.vel);
      end
   end

   initial begin
      img = '0;
      st = '0;
      repeat (20) @(posedge clk);
      rst_b <= 1'b1;
      bus(1'b0, rpd_pkg::ADDR_PARAM_INFO, 32'h0);
      check("subidx", rd, 32'h0000_0006);
      bus(1'b0, 12'h040, 32'h0);
      check("slverr", er, 1'b1);
      for (int k = 0; k < 8; k++) begin
         bus(1'b1, rpd_pkg::ADDR_PARAM_SEL, 32'(k));
         bus(1'b0, rpd_pkg::ADDR_EXCL_LO, 32'h0);
         check("excl_lo", rd, excl[k][31:0]);
         bus(1'b0, rpd_pkg::ADDR_EXCL_HI, 32'h0);
         check("excl_hi", rd, excl[k][47:32]);
      end
      fill();
      st.encoder_channel = img[3:0];
      st.pre = {16'h0, img[31:16]};
      st.stp = {img[43], img[34:32]};
      frame(8'h05, 1'b1);
      fill();
      st.encoder_channel = img[3:0];
      st.pre = img[47:16];
      st.pos = img[79:48];
      frame(8'h0A, 1'b1);
      fill();
      st.encoder_channel = img[3:0];
      st.pre = {16'h0, img[31:16]};
      st.pos = img[63:32];
      frame(8'h09, 1'b1);
      fill();
      st.stp = {img[11], img[2:0]};
      st.vel = img[31:16];
      frame(8'h14, 1'b1);
      fill();
      frame(8'h40, 1'b1);
      for (int k = 0; k < 7; k++) begin
         fill();
         frame(bad[k], 1'b0);
      end
      repeat (3) @(posedge clk);
      check("pending", 48'(expq.size()), 48'h0);
      bus(1'b0, rpd_pkg::ADDR_STATUS, 32'h0);
      check("status", rd, 32'h0000_0503);
      bus(1'b0, rpd_pkg::ADDR_CTRL, 32'h0);
      check("ctrl_rd", rd, 32'h0000_0000);
      bus(1'b1, rpd_pkg::ADDR_STATUS, 32'h0000_0002);
      bus(1'b0, rpd_pkg::ADDR_STATUS, 32'h0);
      check("status_clr", rd, 32'h0000_0501);
      report_and_stop();
   end
endmodule
